// ---- rtl/cnso_core.sv ----
// execution of negate, idle, stack, relative call, soft reset and returns
//
`timescale 1ns/100ps
`include "cnso_defs.svh"
module cnso_core
   import cnso_pkg::*;
(
   input wire logic I_MCLK,
   input wire logic I_RESET,
   input wire logic [15:0] I_INSTR,
   input wire logic I_EXT_SET,
   input wire logic I_PRIO_LOW,
   input wire logic [7:0] I_MEM_RDATA,
   input wire logic [7:0] I_SHADOW_ACC,
   input wire logic [7:0] I_SHADOW_FLAGS,
   input wire logic [3:0] I_SHADOW_BANK,
   output logic [`CNSO_PC_W-1:0] O_PROGRAM_COUNTER,
   output logic O_FETCH,
   output logic [11:0] O_MEM_ADDR,
   output logic O_MEM_INDEXED,
   output logic O_MEM_RD,
   output logic O_MEM_WR,
   output logic [7:0] O_MEM_WDATA,
   output logic [7:0] O_ACC,
   output logic [7:0] O_FLAGS,
   output logic [3:0] O_BANK_SELECT,
   output logic [7:0] O_PRODUCT_HIGH,
   output logic [7:0] O_PRODUCT_LOW,
   output logic O_HIGH_PRIORITY_GLOBAL_ENABLE,
   output logic O_LOW_PRIORITY_GLOBAL_ENABLE,
   output logic [`CNSO_PC_W-1:0] O_STACK_TOP,
   output logic [`CNSO_SP_W-1:0] O_STACK_PTR,
   output logic O_SOFT_RESET
);
   cnso_phase_e phase_reg;
   cnso_cyc_e cyc_reg;
   logic [15:0] ir_reg;
   logic [7:0] opnd_reg;
   logic [8:0] neg_reg;
   logic [4:0] neg_lo_reg;
   logic [`CNSO_SP_W-1:0] sp_reg;
   logic soft_rst_reg;
   logic [`CNSO_PC_W-1:0] top_rdata;
   logic [`CNSO_PC_W-1:0] ret_addr;
   logic [`CNSO_PC_W-1:0] rel_target;
   logic stk_we;
   logic [`CNSO_SP_W-1:0] stk_waddr;
   logic is_idle, is_pop, is_push, is_relative_subroutine_call, is_rst, is_reti, is_literal_return_op, is_neg, is_mul;
   logic exec_q2, exec_q4;

   function automatic logic [`CNSO_SP_W-1:0] sp_step(input logic [`CNSO_SP_W-1:0] sp, input logic up);
      sp_step = up ? sp + `CNSO_SP_W'(1) : sp - `CNSO_SP_W'(1);
   endfunction : sp_step

   // decode of the latched word
   assign is_idle = (ir_reg == `CNSO_OPC_IDLE) || (ir_reg[15:12] == `CNSO_IDLE_HI);
   assign is_pop = ir_reg == `CNSO_OPC_POP;
   assign is_push = ir_reg == `CNSO_OPC_PUSH;
   assign is_rst = ir_reg == `CNSO_OPC_SWRESET;
   assign is_reti = ir_reg[15:1] == `CNSO_RETI_HI;
   assign is_literal_return_op = ir_reg[15:8] == `CNSO_LITERAL_RETURN_OP_HI;
   assign is_relative_subroutine_call = ir_reg[15:11] == `CNSO_RELATIVE_SUBROUTINE_CALL_HI;
   assign is_neg = ir_reg[15:9] == `CNSO_NEG_HI;
   assign is_mul = ir_reg[15:9] == `CNSO_MUL_HI;
   assign exec_q2 = (phase_reg == CNSO_Q2) && (cyc_reg == CNSO_EXEC) && !soft_rst_reg;
   assign exec_q4 = (phase_reg == CNSO_Q4) && (cyc_reg == CNSO_EXEC) && !soft_rst_reg;
   assign ret_addr = O_PROGRAM_COUNTER + `CNSO_PC_STEP;
   // sign-extended offset doubled
   assign rel_target = ret_addr + {{(`CNSO_PC_W-12){ir_reg[10]}}, ir_reg[10:0], 1'b0};
   assign stk_we = exec_q2 && (is_push || is_relative_subroutine_call);
   assign stk_waddr = sp_step(sp_reg, 1'b1);

   cnso_stack_mem u_stack (
      .i_clk(I_MCLK),
      .i_we(stk_we),
      .i_waddr(stk_waddr),
      .i_wdata(ret_addr),
      .i_raddr(sp_reg),
      .o_rdata(top_rdata)
   );

   // quarter phase sequencer
   always_ff @(posedge I_MCLK or posedge I_RESET) begin
      if (I_RESET) begin
         phase_reg <= CNSO_Q1;
      end else begin
         case (phase_reg)
            CNSO_Q1: phase_reg <= CNSO_Q2;
            CNSO_Q2: phase_reg <= CNSO_Q3;
            CNSO_Q3: phase_reg <= CNSO_Q4;
            CNSO_Q4: phase_reg <= CNSO_Q1;
            default: phase_reg <= CNSO_Q1;
         endcase
      end
   end

   // instruction latch, fetch strobe and flush cycle
   always_ff @(posedge I_MCLK or posedge I_RESET) begin
      if (I_RESET) begin
         ir_reg <= 16'h0000;
         cyc_reg <= CNSO_EXEC;
         O_FETCH <= 1'b0;
      end else if (soft_rst_reg) begin
         ir_reg <= 16'h0000;
         cyc_reg <= CNSO_EXEC;
         O_FETCH <= 1'b0;
      end else begin
         O_FETCH <= phase_reg == CNSO_Q4;
         if (phase_reg == CNSO_Q4) begin
            if (cyc_reg == CNSO_EXEC && (is_relative_subroutine_call || is_reti || is_literal_return_op)) begin
               cyc_reg <= CNSO_FLUSH;
               ir_reg <= `CNSO_OPC_IDLE;
            end else begin
               cyc_reg <= CNSO_EXEC;
               ir_reg <= I_INSTR;
            end
         end
      end
   end

   // software master-clear: decoded in Q1, reset asserted from Q2
   always_ff @(posedge I_MCLK or posedge I_RESET) begin
      if (I_RESET) begin
         soft_rst_reg <= 1'b0;
         O_SOFT_RESET <= 1'b0;
      end else begin
         soft_rst_reg <= (phase_reg == CNSO_Q1) && (cyc_reg == CNSO_EXEC) && is_rst && !soft_rst_reg;
         O_SOFT_RESET <= (phase_reg == CNSO_Q1) && (cyc_reg == CNSO_EXEC) && is_rst && !soft_rst_reg;
      end
   end

   // program counter and stack pointer
   always_ff @(posedge I_MCLK or posedge I_RESET) begin
      if (I_RESET) begin
         O_PROGRAM_COUNTER <= `CNSO_PC_RESET;
         sp_reg <= `CNSO_SP_W'(0);
      end else if (soft_rst_reg) begin
         O_PROGRAM_COUNTER <= `CNSO_PC_RESET;
         sp_reg <= `CNSO_SP_W'(0);
      end else begin
         if (exec_q2 && (is_push || is_relative_subroutine_call)) begin
            sp_reg <= stk_waddr;
         end else if (phase_reg == CNSO_Q3 && cyc_reg == CNSO_EXEC && (is_pop || is_reti || is_literal_return_op)) begin
            sp_reg <= sp_step(sp_reg, 1'b0);
         end
         if (exec_q4) begin
            if (is_relative_subroutine_call) begin
               O_PROGRAM_COUNTER <= rel_target;
            end else if (is_reti || is_literal_return_op) begin
               O_PROGRAM_COUNTER <= O_STACK_TOP;
            end else begin
               O_PROGRAM_COUNTER <= ret_addr;
            end
         end
         // no step in the flush slot, so the next word runs at the new counter
      end
   end

   // stack top mirror, taken once the stack read settles
   always_ff @(posedge I_MCLK or posedge I_RESET) begin
      if (I_RESET) begin
         O_STACK_TOP <= `CNSO_PC_RESET;
         O_STACK_PTR <= `CNSO_SP_W'(0);
      end else begin
         if (phase_reg == CNSO_Q3 && cyc_reg == CNSO_EXEC && (is_reti || is_literal_return_op)) begin
            O_STACK_TOP <= top_rdata; // popped value held for Q4 load
         end else if (phase_reg == CNSO_Q1 || phase_reg == CNSO_Q2) begin
            O_STACK_TOP <= top_rdata;
         end
         O_STACK_PTR <= sp_reg;
      end
   end

   // data memory addressing and operand read
   always_ff @(posedge I_MCLK or posedge I_RESET) begin
      if (I_RESET) begin
         O_MEM_ADDR <= 12'h000;
         O_MEM_INDEXED <= 1'b0;
         O_MEM_RD <= 1'b0;
         opnd_reg <= 8'h00;
      end else begin
         O_MEM_RD <= (phase_reg == CNSO_Q1) && (cyc_reg == CNSO_EXEC) && (is_neg || is_mul);
         if (phase_reg == CNSO_Q1) begin
            if (!ir_reg[8]) begin
               O_MEM_INDEXED <= I_EXT_SET && (ir_reg[7:0] <= `CNSO_IDX_LIMIT);
               O_MEM_ADDR <= {{4{ir_reg[7]}}, ir_reg[7:0]};
            end else begin
               O_MEM_INDEXED <= 1'b0;
               O_MEM_ADDR <= {O_BANK_SELECT, ir_reg[7:0]};
            end
         end
         if (phase_reg == CNSO_Q3) begin
            opnd_reg <= I_MEM_RDATA;
         end
      end
   end

   // negate result formed as the operand is read, ready for the Q4 write
   always_ff @(posedge I_MCLK or posedge I_RESET) begin
      if (I_RESET) begin
         neg_reg <= 9'h000;
         neg_lo_reg <= 5'h00;
      end else if (phase_reg == CNSO_Q3) begin
         neg_reg <= {1'b0, ~I_MEM_RDATA} + 9'h001;
         neg_lo_reg <= {1'b0, ~I_MEM_RDATA[3:0]} + 5'h01;
      end
   end

   // write-back to data memory
   always_ff @(posedge I_MCLK or posedge I_RESET) begin
      if (I_RESET) begin
         O_MEM_WR <= 1'b0;
         O_MEM_WDATA <= 8'h00;
      end else begin
         O_MEM_WR <= exec_q4 && is_neg;
         O_MEM_WDATA <= neg_reg[7:0];
      end
   end

   // accumulator, flags, bank select, product pair
   always_ff @(posedge I_MCLK or posedge I_RESET) begin
      if (I_RESET) begin
         O_ACC <= 8'h00;
         O_FLAGS <= 8'h00;
         O_BANK_SELECT <= 4'h0;
         O_PRODUCT_HIGH <= 8'h00;
         O_PRODUCT_LOW <= 8'h00;
      end else if (soft_rst_reg) begin
         O_ACC <= 8'h00;
         O_FLAGS <= 8'h00;
         O_BANK_SELECT <= 4'h0;
         O_PRODUCT_HIGH <= 8'h00;
         O_PRODUCT_LOW <= 8'h00;
      end else if (exec_q4) begin
         if (is_mul) begin
            {O_PRODUCT_HIGH, O_PRODUCT_LOW} <= {8'h00, O_ACC} * {8'h00, opnd_reg};
         end
         if (is_neg) begin
            O_FLAGS[`CNSO_FLAG_N] <= neg_reg[7];
            O_FLAGS[`CNSO_FLAG_OV] <= opnd_reg == 8'h80;
            O_FLAGS[`CNSO_FLAG_C] <= neg_reg[8];
            O_FLAGS[`CNSO_FLAG_DC] <= neg_lo_reg[4];
            O_FLAGS[`CNSO_FLAG_Z] <= neg_reg[7:0] == 8'h00;
         end
         if (is_literal_return_op) begin
            O_ACC <= ir_reg[7:0];
         end
         if (is_reti && ir_reg[0]) begin
            O_ACC <= I_SHADOW_ACC;
            O_FLAGS <= I_SHADOW_FLAGS;
            O_BANK_SELECT <= I_SHADOW_BANK;
         end
         // restore bit clear keeps accumulator, flags and bank
      end
   end

   // global enables re-armed by interrupt return
   always_ff @(posedge I_MCLK or posedge I_RESET) begin
      if (I_RESET) begin
         O_HIGH_PRIORITY_GLOBAL_ENABLE <= 1'b0;
         O_LOW_PRIORITY_GLOBAL_ENABLE <= 1'b0;
      end else if (soft_rst_reg) begin
         O_HIGH_PRIORITY_GLOBAL_ENABLE <= 1'b0;
         O_LOW_PRIORITY_GLOBAL_ENABLE <= 1'b0;
      end else if (exec_q4 && is_reti) begin
         if (I_PRIO_LOW) begin
            O_LOW_PRIORITY_GLOBAL_ENABLE <= 1'b1;
         end else begin
            O_HIGH_PRIORITY_GLOBAL_ENABLE <= 1'b1;
         end
      end
   end

   chk_neg_result: assert property (@(posedge I_MCLK) disable iff (I_RESET)
      O_MEM_WR |-> O_MEM_WDATA == 8'(~$past(opnd_reg) + 8'h01))
      else $error("negate result wrong");
   chk_idle_flags: assert property (@(posedge I_MCLK) disable iff (I_RESET)
      (exec_q4 && is_idle) |=> $stable(O_FLAGS) && $stable(O_ACC) && !O_MEM_WR)
      else $error("idle changed state");
   chk_pop_depth: assert property (@(posedge I_MCLK) disable iff (I_RESET)
      (phase_reg == CNSO_Q3 && cyc_reg == CNSO_EXEC && is_pop && !soft_rst_reg) |=> sp_reg == $past(sp_reg) - 5'd1)
      else $error("pop did not drop stack");
   chk_push_value: assert property (@(posedge I_MCLK) disable iff (I_RESET)
      (exec_q2 && is_push) |=> ##1 top_rdata == $past(ret_addr, 2))
      else $error("push stored wrong address");
   chk_call_target: assert property (@(posedge I_MCLK) disable iff (I_RESET)
      (exec_q4 && is_relative_subroutine_call) |=> (O_PROGRAM_COUNTER == $past(rel_target) && cyc_reg == CNSO_FLUSH)
      ##3 (cyc_reg == CNSO_FLUSH) ##1 (cyc_reg == CNSO_EXEC && O_PROGRAM_COUNTER == $past(rel_target, 5)))
      else $error("relative call target wrong");
   chk_reset_q2: assert property (@(posedge I_MCLK) disable iff (I_RESET)
      soft_rst_reg |=> O_PROGRAM_COUNTER == `CNSO_PC_RESET && O_ACC == 8'h00)
      else $error("soft reset incomplete");
   chk_reti_enable: assert property (@(posedge I_MCLK) disable iff (I_RESET)
      (exec_q4 && is_reti) |=> (O_HIGH_PRIORITY_GLOBAL_ENABLE || O_LOW_PRIORITY_GLOBAL_ENABLE))
      else $error("interrupt return left enables off");
   chk_literal_return_op_acc: assert property (@(posedge I_MCLK) disable iff (I_RESET)
      (exec_q4 && is_literal_return_op) |=> O_ACC == $past(ir_reg[7:0]))
      else $error("literal return accumulator wrong");
endmodule : cnso_core

// ---- rtl/cnso_defs.svh ----
// constants for the negate, stack and return execution block
`ifndef CNSO_DEFS_SVH
`define CNSO_DEFS_SVH
`define CNSO_OPC_IDLE 16'h0000
`define CNSO_OPC_POP 16'h0006
`define CNSO_OPC_PUSH 16'h0005
`define CNSO_OPC_SWRESET 16'h00FF
`define CNSO_RETI_HI 15'h0008
`define CNSO_MUL_HI 7'h01
`define CNSO_NEG_HI 7'h36
`define CNSO_LITERAL_RETURN_OP_HI 8'h0C
`define CNSO_RELATIVE_SUBROUTINE_CALL_HI 5'h1B
`define CNSO_IDLE_HI 4'hF
`define CNSO_IDX_LIMIT 8'h5F
`define CNSO_PC_STEP 21'h000002
`define CNSO_STK_DEPTH 31
`define CNSO_SP_W 5
`define CNSO_PC_W 21
`define CNSO_PC_RESET 21'h000000
`define CNSO_FLAG_C 0
`define CNSO_FLAG_DC 1
`define CNSO_FLAG_Z 2
`define CNSO_FLAG_OV 3
`define CNSO_FLAG_N 4
`endif

// ---- rtl/cnso_pkg.sv ----
// types for the negate, stack and return execution block
package cnso_pkg;
   typedef enum logic [1:0] {
      CNSO_Q1 = 2'b00,
      CNSO_Q2 = 2'b01,
      CNSO_Q3 = 2'b11,
      CNSO_Q4 = 2'b10
   } cnso_phase_e;
   typedef enum logic [1:0] {
      CNSO_EXEC = 2'b00,
      CNSO_FLUSH = 2'b01
   } cnso_cyc_e;
endpackage : cnso_pkg

// ---- rtl/cnso_stack_mem.sv ----
// return stack storage with registered read data
`timescale 1ns/100ps
`include "cnso_defs.svh"
module cnso_stack_mem (
   input wire logic i_clk,
   input wire logic i_we,
   input wire logic [`CNSO_SP_W-1:0] i_waddr,
   input wire logic [`CNSO_PC_W-1:0] i_wdata,
   input wire logic [`CNSO_SP_W-1:0] i_raddr,
   output logic [`CNSO_PC_W-1:0] o_rdata
);
   logic [`CNSO_PC_W-1:0] mem [0:`CNSO_STK_DEPTH];
   always_ff @(posedge i_clk) begin
      if (i_we) begin
         mem[i_waddr] <= i_wdata;
      end
   end
   // write-through so a top just written is visible next cycle
   always_ff @(posedge i_clk) begin
      if (i_we && (i_waddr == i_raddr)) begin
         o_rdata <= i_wdata;
      end else begin
         o_rdata <= mem[i_raddr];
      end
   end
endmodule : cnso_stack_mem

// ---- verif/cnso_core_tb.sv ----
// self-checking bench for the negate, stack and return execution block
`timescale 1ns/100ps
`include "cnso_defs.svh"
module cnso_core_tb;
   logic clk, rst, ext, prio, fetch, m_idx, m_rd, m_wr, hen, len, srst;
   logic [15:0] instr;
   logic [7:0] rdata, m_wdata, acc, flags, ph, pl;
   logic [3:0] bank;
   logic [4:0] sp;
   logic [11:0] m_addr;
   logic [20:0] pc, top;
   int num_errors = 0;
   int total_checks = 0;
   int cycles = 0;
   int srst_seen = 0;
   int fetch_seen = 0;
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   cnso_core u_dut (.I_MCLK(clk), .I_RESET(rst), .I_INSTR(instr), .I_EXT_SET(ext), .I_PRIO_LOW(prio),
      .I_MEM_RDATA(rdata), .I_SHADOW_ACC(8'h7E), .I_SHADOW_FLAGS(8'h1B), .I_SHADOW_BANK(4'h3),
      .O_PROGRAM_COUNTER(pc), .O_FETCH(fetch), .O_MEM_ADDR(m_addr), .O_MEM_INDEXED(m_idx), .O_MEM_RD(m_rd),
      .O_MEM_WR(m_wr), .O_MEM_WDATA(m_wdata), .O_ACC(acc), .O_FLAGS(flags), .O_BANK_SELECT(bank),
      .O_PRODUCT_HIGH(ph), .O_PRODUCT_LOW(pl), .O_HIGH_PRIORITY_GLOBAL_ENABLE(hen),
      .O_LOW_PRIORITY_GLOBAL_ENABLE(len), .O_STACK_TOP(top), .O_STACK_PTR(sp), .O_SOFT_RESET(srst));
   cnso_data_mem u_mem (.i_clk(clk), .i_rd(m_rd), .i_wr(m_wr), .i_indexed(m_idx), .i_addr(m_addr),
      .i_wdata(m_wdata), .o_rdata(rdata));
   task complete_run;
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : complete_run
   // 106 instruction words (about 430 clocks) are issued, well below this ceiling
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (srst === 1'b1) srst_seen <= srst_seen + 1;
      if (fetch === 1'b1) fetch_seen <= fetch_seen + 1;
      if (cycles == 2000) begin
         num_errors++;
         complete_run;
      end
   end
   task check(input string name, input logic [20:0] seen, input logic [20:0] exp);
      total_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("MISMATCH %s expected %0h seen %0h", name, exp, seen);
      end
   endtask : check
   // one instruction word held across a whole four-clock cycle
   task exec(input logic [15:0] w);
      instr <= w;
      repeat (4) @(posedge clk);
   endtask : exec
   task settle;
      exec(`CNSO_OPC_IDLE);
      exec(`CNSO_OPC_IDLE);
      #1;
   endtask : settle
   task t_stack;
      logic [20:0] t1;
      exec(`CNSO_OPC_PUSH);
      settle;
      t1 = top;
      check("sp_push", sp, 1);
      exec(`CNSO_OPC_PUSH);
      settle;
      check("top_push", top, t1 + 21'd6);
      exec(`CNSO_OPC_POP);
      settle;
      check("top_pop", top, t1);
      check("sp_pop", sp, 1);
      check("flags_stack", flags, 0);
   endtask : t_stack
   task t_relative_subroutine_call(input logic [10:0] n);
      logic [20:0] t1;
      logic [4:0] s1;
      exec(`CNSO_OPC_PUSH);
      settle;
      t1 = top;
      s1 = sp;
      // a push offered in the flush slot must be dropped
      exec({5'b11011, n});
      exec(`CNSO_OPC_PUSH);
      settle;
      check("relative_subroutine_call_top", top, t1 + 21'd6);
      check("relative_subroutine_call_sp", sp, s1 + 5'd1);
      exec(`CNSO_OPC_PUSH);
      settle;
      check("relative_subroutine_call_pc", top, t1 + 21'd12 + {{9{n[10]}}, n, 1'b0});
      repeat (3) exec(`CNSO_OPC_POP);
      settle;
   endtask : t_relative_subroutine_call
   task t_ret(input logic [15:0] w);
      logic [20:0] t1;
      logic [4:0] s0;
      exec(`CNSO_OPC_PUSH);
      settle;
      t1 = top;
      s0 = sp - 5'd1;
      exec(w);
      exec(`CNSO_OPC_PUSH);
      settle;
      check("ret_sp", sp, s0);
      exec(`CNSO_OPC_PUSH);
      settle;
      check("ret_pc", top, t1 + 21'd6);
      exec(`CNSO_OPC_POP);
      settle;
   endtask : t_ret
   task t_mul;
      logic [7:0] f0;
      f0 = flags;
      exec({7'h01, 1'b0, 8'hB5});
      settle;
      check("mul_prod", {ph, pl}, 16'h8A94);
      check("mul_keep", {acc, flags}, {8'hC4, f0});
      check("mul_addr", u_mem.rd_addr, 12'hFB5);
   endtask : t_mul
   task t_neg(input logic a, input logic [7:0] f, input logic e, input logic [11:0] ea);
      logic [7:0] v;
      logic [7:0] r;
      logic x;
      x = e && !a && (f <= 8'h5F);
      ext <= e;
      exec({7'h36, a, f});
      settle;
      v = u_mem.held;
      r = ~v + 8'd1;
      check("neg_idx", u_mem.rd_idx, x);
      if (x == 1'b0) check("neg_addr", u_mem.rd_addr, ea);
      check("neg_wr_addr", u_mem.wr_addr, u_mem.rd_addr);
      check("neg_data", u_mem.wr_data, r);
      check("neg_flags", flags[4:0], {r[7], v == 8'h80, r == 8'h00, v[3:0] == 4'h0, v == 8'h00});
      ext <= 1'b0;
   endtask : t_neg
   task t_idle;
      logic [20:0] p;
      logic [15:0] k;
      int f;
      p = pc;
      k = {acc, flags};
      f = fetch_seen;
      exec(16'h0000);
      exec(16'hF123);
      settle;
      check("idle_pc", pc, p + 21'd8);
      check("idle_fetch", fetch_seen - f, 4);
      check("idle_keep", {acc, flags}, k);
   endtask : t_idle
   task t_soft;
      exec(`CNSO_OPC_SWRESET);
      settle;
      check("srst_pulse", srst_seen, 1);
      check("srst_regs", {acc, flags, bank}, 0);
      check("srst_more", {sp, hen, len}, 0);
      check("srst_prod", {ph, pl}, 0);
   endtask : t_soft
   initial begin
      rst = 1'b1;
      ext = 1'b0;
      prio = 1'b0;
      instr = `CNSO_OPC_IDLE;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      #1;
      check("pc_rst", pc, 0);
      t_stack;
      t_relative_subroutine_call(11'h3FF);
      t_relative_subroutine_call(11'h400);
      t_ret({8'h0C, 8'hC4});
      check("literal_return_op_acc", acc, 8'hC4);
      t_mul;
      t_ret(16'h0010);
      check("reti_hen", {hen, len}, 2'b10);
      check("reti_keep", {acc, bank}, {8'hC4, 4'h0});
      prio <= 1'b1;
      t_ret(16'h0011);
      check("reti_len", {hen, len}, 2'b11);
      check("reti_shadow", {acc, flags, bank}, {8'h7E, 8'h1B, 4'h3});
      t_neg(1'b0, 8'h3A, 1'b0, 12'h03A);
      t_neg(1'b0, 8'h80, 1'b0, 12'hF80);
      t_neg(1'b0, 8'h00, 1'b0, 12'h000);
      t_neg(1'b1, 8'h5F, 1'b1, 12'h35F);
      t_neg(1'b0, 8'h5F, 1'b1, 12'h000);
      t_neg(1'b0, 8'h60, 1'b1, 12'h060);
      t_idle;
      t_soft;
      complete_run;
   end
endmodule : cnso_core_tb

// ---- verif/cnso_data_mem.sv ----
// partner model: banked data memory serving the core's operand reads and writes
`timescale 1ns/100ps
module cnso_data_mem (
   input wire logic i_clk,
   input wire logic i_rd,
   input wire logic i_wr,
   input wire logic i_indexed,
   input wire logic [11:0] i_addr,
   input wire logic [7:0] i_wdata,
   output logic [7:0] o_rdata
);
   logic [7:0] mem [0:4095];
   logic [7:0] held;
   logic hold;
   logic rd_idx;
   logic [11:0] rd_addr;
   logic [11:0] wr_addr;
   logic [7:0] wr_data;
   initial begin
      held = 8'h00;
      hold = 1'b0;
      for (int i = 0; i < 4096; i++) begin
         mem[i] = i[7:0];
      end
   end
   // data stand one extra cycle, then the line shows the inverse of the last value
   assign o_rdata = i_rd ? mem[i_addr] : (hold ? held : ~held);
   always @(posedge i_clk) begin
      hold <= i_rd;
      if (i_rd) begin
         held <= mem[i_addr];
         rd_addr <= i_addr;
         rd_idx <= i_indexed;
      end
      if (i_wr) begin
         mem[i_addr] <= i_wdata;
         wr_addr <= i_addr;
         wr_data <= i_wdata;
      end
   end
endmodule : cnso_data_mem
